//--- hdl/srh_ctrl.sv
// Host-side controller driving a 256 x 1 asynchronous static RAM.
// Assumes the memory pins are wired directly and the user port is on clock.
// Every phase length comes from a package count (read and read recovery add 2); nothing here is programmable.
// Pins move only on clock edges, so the memory sees clean edge ordering.
// The user must hold a request and its fields until req_ready is high.
`timescale 1ns/1ps
module srh_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic req_wdata,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic rsp_error,
  output logic [7:0] location_select,
  output logic chip_select_n,
  output logic read_write_n,
  output logic data_in,
  input wire logic data_out,
  input wire logic data_out_n
);
  // Sequencer state and phase counter.
  srh_pkg::srh_state_t state_reg;
  srh_pkg::srh_state_t state_next;
  logic [srh_pkg::CNT_W-1:0] cnt_reg;
  logic [srh_pkg::CNT_W-1:0] cnt_next;
  // Registered memory pins.
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic cs_n_reg;
  logic cs_n_next;
  logic rw_reg;
  logic rw_next;
  logic din_reg;
  logic din_next;
  // Registered response to the user.
  logic rvalid_reg;
  logic rvalid_next;
  logic rdata_reg;
  logic rdata_next;
  logic rerr_reg;
  logic rerr_next;
  logic [1:0] pins_sync;

  // Memory outputs come from another timing domain.
  // The memory has no clock, so its outputs may change at any instant.
  srh_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({data_out, data_out_n}),
    .sync_out(pins_sync)
  );

  // A counter loads n - 1 so that its phase lasts exactly n cycles.
  function automatic logic [srh_pkg::CNT_W-1:0] cyc(input int n);
    cyc = (srh_pkg::CNT_W)'(n - 1);
  endfunction

  function automatic logic cnt_zero(input logic [srh_pkg::CNT_W-1:0] c);
    cnt_zero = (c == '0);
  endfunction

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    cs_n_next = cs_n_reg;
    rw_next = rw_reg;
    din_next = din_reg;
    rvalid_next = 1'b0;
    rdata_next = rdata_reg;
    rerr_next = rerr_reg;

    case (state_reg)
      srh_pkg::SRH_IDLE: begin
        if (req_valid) begin
          // Address may change with select high.
          addr_next = req_addr;
          din_next = req_wdata;
          cnt_next = cyc(srh_pkg::ADS_CYC);
          state_next = srh_pkg::SRH_SETUP;
        end
      end

      srh_pkg::SRH_SETUP: begin
        if (cnt_reg == '0) begin
          // Select low only for an access.
          cs_n_next = 1'b0;
          if (req_write) begin
            rw_next = 1'b1;
            cnt_next = cyc(srh_pkg::WRW_CYC);
            state_next = srh_pkg::SRH_WPULSE;
          end else begin
            // Two extra cycles cover the synchroniser lag, so the data
            // sampled at the end is the settled read value.
            cnt_next = cyc(srh_pkg::ACC_CYC + 2);
            state_next = srh_pkg::SRH_READ;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end

      srh_pkg::SRH_READ: begin
        if (cnt_reg == '0) begin
          // True output carries the stored bit.
          rdata_next = pins_sync[1];
          // Outputs must be complementary once driven.
          rerr_next = ~(pins_sync[1] ^ pins_sync[0]);
          rvalid_next = 1'b1;
          cs_n_next = 1'b1;
          cnt_next = cyc(srh_pkg::DOH_CYC + 2);
          state_next = srh_pkg::SRH_RECOVER;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end

      srh_pkg::SRH_WPULSE: begin
        if (cnt_reg == '0) begin
          // Select rising first ends the write pulse.
          cs_n_next = 1'b1;
          cnt_next = cyc(srh_pkg::WRH_CYC);
          state_next = srh_pkg::SRH_WHOLD;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end

      // Select is already high here, which keeps the pulse inside it.
      srh_pkg::SRH_WHOLD: begin
        if (cnt_reg == '0) begin
          // Command falls after select is high.
          rw_next = 1'b0;
          cnt_next = cyc(srh_pkg::DIH_CYC);
          rvalid_next = 1'b1;
          rerr_next = 1'b0;
          state_next = srh_pkg::SRH_RECOVER;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end

      // Recovery lets the outputs float before the next address moves.
      srh_pkg::SRH_RECOVER: begin
        // Data input held past command fall.
        if (cnt_reg == '0) begin
          state_next = srh_pkg::SRH_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end

      // An unknown state parks the pins idle rather than guess an access.
      default: begin
        state_next = srh_pkg::SRH_IDLE;
        cs_n_next = 1'b1;
        rw_next = 1'b0;
      end
    endcase
  end

  // Pins reset to idle so the memory is deselected from the first edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= srh_pkg::SRH_IDLE;
      cnt_reg <= '0;
      addr_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      rw_reg <= 1'b0;
      din_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 1'b0;
      rerr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      cs_n_reg <= cs_n_next;
      rw_reg <= rw_next;
      din_reg <= din_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rerr_reg <= rerr_next;
    end
  end

  // The request is held by the user until taken in the setup phase.
  // Ready is combinational, so the request is taken on the same edge.
  assign req_ready = (state_reg == srh_pkg::SRH_SETUP) && cnt_zero(cnt_reg);
  assign rsp_valid = rvalid_reg;
  assign rsp_rdata = rdata_reg;
  assign rsp_error = rerr_reg;
  // Pins come straight from flip-flops so the memory sees no glitches.
  assign location_select = addr_reg;
  assign chip_select_n = cs_n_reg;
  assign read_write_n = rw_reg;
  assign data_in = din_reg;
endmodule // srh_ctrl

//--- hdl/srh_sync.sv
// Two-flop synchroniser for the memory data outputs.
// Assumes the inputs arrive asynchronously from the memory pins.
`timescale 1ns/1ps
module srh_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // srh_sync

//--- pkg/srh_pkg.sv
// Package for the host-side controller of a 256 x 1 asynchronous static RAM.
// Assumes a single 250 MHz clock; the memory itself has no clock or reset.
package srh_pkg;
  localparam int ADDR_W = 8;
  localparam int DEPTH = 256;
  // Clock period in picoseconds (250 MHz).
  localparam int CLK_PS = 4000;
  // Timing figures in nanoseconds, slow-supply column.
  localparam int T_ADS_NS = 40;
  localparam int T_ACC_NS = 850;
  localparam int T_DOH_NS = 65;
  localparam int T_WRW_NS = 330;
  localparam int T_WRH_NS = 40;
  localparam int T_DIH_NS = 40;
  // Cycle counts, least times rounded up.
  localparam int ADS_CYC = (T_ADS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DOH_CYC = (T_DOH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WRW_CYC = (T_WRW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WRH_CYC = (T_WRH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DIH_CYC = (T_DIH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {
    SRH_IDLE, SRH_SETUP, SRH_READ, SRH_WPULSE, SRH_WHOLD, SRH_RECOVER
  } srh_state_t;
endpackage

//--- verif/srh_ctrl_sva.sv
// Checker on the ports of the memory controller.
// Assumes it is bound onto every srh_ctrl.
`timescale 1ns/1ps
module srh_ctrl_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rsp_valid,
  input wire logic [7:0] location_select,
  input wire logic chip_select_n,
  input wire logic read_write_n,
  input wire logic data_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rd_go; req_ready && !req_write; endsequence
  sequence wr_go; req_ready && req_write; endsequence
  sel_addr_a: assert property (
    !chip_select_n && $past(!chip_select_n) |-> $stable(location_select))
    else $error("address moved under select");
  cmd_inside_a: assert property (
    $rose(read_write_n) |-> !chip_select_n) else $error("write outside");
  cmd_fall_a: assert property (
    $fell(read_write_n) |-> chip_select_n && $past(chip_select_n))
    else $error("command fell early");
  din_hold_a: assert property (
    $past(read_write_n) |-> $stable(data_in)) else $error("data moved");
  rd_resp_a: assert property (
    rd_go |-> ##[214:216] rsp_valid) else $error("read answer late");
  wr_resp_a: assert property (
    wr_go |-> ##[93:95] rsp_valid) else $error("write answer late");
  go_sel_a: assert property (
    req_ready |-> ##[0:1] !chip_select_n) else $error("select not low");
  resp_idle_a: assert property (
    rsp_valid |-> chip_select_n) else $error("select low at answer");
endmodule // srh_ctrl_sva
bind srh_ctrl srh_ctrl_sva chk_u (.clock(clock), .rst_n(rst_n),
  .req_ready(req_ready), .req_write(req_write), .rsp_valid(rsp_valid),
  .location_select(location_select), .chip_select_n(chip_select_n),
  .read_write_n(read_write_n), .data_in(data_in));

//--- verif/srh_ctrl_test.sv
// Self-checking bench for srh_ctrl against the memory model.
// Assumes the checker is bound; no software registers exist.
`timescale 1ns/1ps
module srh_ctrl_test;
  logic clock = 0, rst_n = 0, req_valid = 0, req_write = 0, req_wdata = 0;
  logic [7:0] req_addr = 8'h00, location_select;
  logic req_ready, rsp_valid, rsp_rdata, rsp_error, chip_select_n;
  logic read_write_n, data_in, data_out, data_out_n, r, e;
  int error_cnt = 0, cmp_count = 0;
  always #2 clock = ~clock;
  srh_ctrl dut_u (.*);
  srh_mem_model mem_u (.*);
  task automatic chk(string n, logic x, logic g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %b got %b", n, x, g);
    end
  endtask
  task automatic op(logic w, logic [7:0] a, logic d);
    int i;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    for (i = 0; i < 60 && req_ready !== 1'b1; i++) @(posedge clock) #1;
    @(posedge clock) #1 req_valid = 0;
    for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(posedge clock) #1;
    chk("rsp_valid", 1'b1, rsp_valid);
    r = rsp_rdata;
    e = rsp_error;
    @(posedge clock) #1;
  endtask
  task automatic t_reset;
    chk("chip_select_n", 1'b1, chip_select_n);
    chk("read_write_n", 1'b0, read_write_n);
    $display("test reset done");
  endtask
  task automatic t_bounds;
    op(1, 8'h00, 1);
    op(1, 8'hff, 0);
    op(0, 8'h00, 0);
    chk("rdata 00", 1'b1, r);
    chk("error", 1'b0, e);
    op(0, 8'hff, 1);
    chk("rdata ff", 1'b0, r);
    $display("test bounds done");
  endtask
  task automatic t_rewrite;
    op(1, 8'h5a, 0);
    op(0, 8'h5a, 1);
    chk("rdata 5a", 1'b0, r);
    op(1, 8'h5a, 1);
    op(0, 8'h5a, 0);
    chk("rdata 5a", 1'b1, r);
    chk("error", 1'b0, e);
    $display("test rewrite done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clock);
    #1 rst_n = 1;
    @(posedge clock) #1;
    t_reset();
    t_bounds();
    t_rewrite();
    complete_run();
  end
endmodule // srh_ctrl_test

//--- verif/srh_mem_model.sv
// Behavioural model of the 256 x 1 static memory pins.
// Assumes the controller drives the pins directly.
`timescale 1ns/1ps
module srh_mem_model (
  input wire logic clock,
  input wire logic [7:0] location_select,
  input wire logic chip_select_n,
  input wire logic read_write_n,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_n
);
  logic mem [256];
  logic flip = 1'b0;
  logic drive;
  // A float toggles, so a stale level is never taken for data.
  always @(posedge clock) flip <= ~flip;
  always @(posedge chip_select_n or negedge read_write_n)
    if (read_write_n || !chip_select_n) mem[location_select] <= data_in;
  assign drive = !chip_select_n && !read_write_n;
  assign data_out = drive ? mem[location_select] : flip;
  assign data_out_n = drive ? ~mem[location_select] : flip;
endmodule // srh_mem_model
